// File: core/rhs_pkg.sv
// Constants for the receive packet and code status block.
// Assumes one 100 MHz clock and an 8-bit register port.
package rhs_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_PKT_INFO  = 8'h03;
  localparam logic [7:0] ADDR_CODE_STAT = 8'h04;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h05;
  localparam logic [7:0] ADDR_EVT_STAT  = 8'h10;
  localparam logic [7:0] ADDR_EVT_MASK  = 8'h11;

  // ==========================================================
  // Packet info bit positions
  localparam int PI_ABORT = 7;
  localparam int PI_CRCE  = 6;
  localparam int PI_OVR   = 5;
  localparam int PI_VALID = 4;
  localparam int PI_EMPTY = 3;
  localparam int PI_OK    = 2;
  localparam int PI_CLOSE = 1;
  localparam int PI_OPEN  = 0;

  // Code status bit positions
  localparam int CS_LATCH = 7;
  localparam int CS_LIVE  = 6;

  // Event status / mask bit positions
  localparam int EV_ABORT = 0;
  localparam int EV_CRCE  = 1;
  localparam int EV_OVR   = 2;
  localparam int EV_VALID = 3;
  localparam int EV_CODE  = 4;
  localparam int EV_W     = 5;

  // ==========================================================
  // Reset values and link constants
  localparam logic [5:0]  CODE_RESET    = 6'h3F;
  localparam logic [2:0]  ONES_ABORT    = 3'h6;
  localparam logic [2:0]  ONES_STUFF    = 3'h5;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY      = 16'h8408;
  localparam logic [15:0] CRC_RESIDUAL  = 16'hF0B8;
  localparam logic [1:0]  CODE_CONFIRM  = 2'h2;
  localparam logic [5:0]  CODE_LOSS     = 6'h20;

  // ==========================================================
  // FIFO shape
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW    = 6;
  localparam int FIFO_W     = 11;

endpackage : rhs_pkg

// File: core/rhs_tag_fifo.sv
// Receive byte FIFO carrying per-byte frame tags.
// Assumes push and pop are one-cycle strobes on sys_clk.
`timescale 1ns/1ps
module rhs_tag_fifo
  import rhs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              push,
  input  wire logic [FIFO_W-1:0] push_data,
  input  wire logic              pop,
  output logic      [FIFO_W-1:0] head_data,
  output logic                   empty,
  output logic                   full
);

  // ==========================================================
  // Storage and pointers
  logic [FIFO_W-1:0] mem_ff [FIFO_DEPTH];
  logic [FIFO_AW:0]  wr_ptr_ff;
  logic [FIFO_AW:0]  rd_ptr_ff;
  wire               do_push;
  wire               do_pop;

  // Extra pointer bit tells full from empty
  assign empty   = wr_ptr_ff == rd_ptr_ff;
  assign full    = (wr_ptr_ff[FIFO_AW] != rd_ptr_ff[FIFO_AW]) &&
                   (wr_ptr_ff[FIFO_AW-1:0] == rd_ptr_ff[FIFO_AW-1:0]);
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign head_data = mem_ff[rd_ptr_ff[FIFO_AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff[FIFO_AW-1:0]] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + {{FIFO_AW{1'b0}}, do_push};
      rd_ptr_ff <= rd_ptr_ff + {{FIFO_AW{1'b0}}, do_pop};
    end
  end

endmodule : rhs_tag_fifo

// File: core/rhs_top.sv
// Receive data link packet status and bit-oriented code detector.
// Assumes link bits arrive with a one-cycle enable, synchronous to sys_clk.
//
// Overview of operation
// - Seven or more consecutive ones on the link set the abort flag.
// - Checksum mismatch at packet end sets the checksum error flag.
// - Pushing a byte into a full FIFO sets the overrun flag.
// - A complete, checked packet sets the valid message flag.
// - FIFO empty bit is live: high exactly while FIFO holds nothing.
// - Packet OK tag high when head byte ends a valid message.
// - Closing tag high when head byte ends any message.
// - Opening tag high when head byte starts a message.
// - Abort, checksum, overrun and valid flags are sticky, cleared by read.
// - Live code bit high while a valid code is being received.
// - Latched code bit sets on live rise, clears on code register read.
// - Code bit 0 is first received, bit 5 last received.
// - Code bits show latest verified code; reset forces all ones.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module rhs_top
  import rhs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       link_bit,
  input  wire logic       link_bit_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq
);

  // ==========================================================
  // Checksum step, reflected CCITT polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic        b);
    crc_step = {1'b0, crc[15:1]} ^ ((crc[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction : crc_step

  // ==========================================================
  // Framer state
  logic [2:0]  ones_ff,     nxt_ones;
  logic        in_frame_ff, nxt_in_frame;
  logic [2:0]  bit_cnt_ff,  nxt_bit_cnt;
  logic [7:0]  shift_ff,    nxt_shift;
  logic [15:0] crc_ff,      nxt_crc;
  logic [15:0] crc_bnd_ff,  nxt_crc_bnd;
  logic [7:0]  hold_ff,     nxt_hold;
  logic        hold_v_ff,   nxt_hold_v;
  logic        hold_op_ff,  nxt_hold_op;
  logic        first_ff,    nxt_first;
  logic        ovr_fr_ff,   nxt_ovr_fr;

  // Per-cycle results of the framer
  logic              push;
  logic [FIFO_W-1:0] push_data;
  logic              ev_abort;
  logic              ev_crce;
  logic              ev_valid;
  logic [FIFO_W-1:0] head;
  logic              fifo_empty;
  logic              fifo_full;

  // ==========================================================
  // Bit classification
  wire        abort_hit = link_bit_en & link_bit & (ones_ff == ONES_ABORT);
  wire        flag_hit  = link_bit_en & ~link_bit & (ones_ff == ONES_ABORT);
  wire        stuff_hit = link_bit_en & ~link_bit & (ones_ff == ONES_STUFF);
  wire        data_hit  = link_bit_en & in_frame_ff & ~abort_hit &
                          ~flag_hit & ~stuff_hit;
  wire [7:0]  byte_new  = {link_bit, shift_ff[7:1]};
  wire [15:0] crc_new   = crc_step(crc_ff, link_bit);
  wire        byte_done = data_hit & (bit_cnt_ff == 3'h7);
  // Flag's own leading 0111111 lands as seven data bits
  wire        aligned   = bit_cnt_ff == 3'h7;
  wire        crc_good  = aligned & (crc_bnd_ff == CRC_RESIDUAL);
  wire        frame_end = flag_hit & in_frame_ff & hold_v_ff;

  always_comb begin
    nxt_ones     = ones_ff;
    nxt_in_frame = in_frame_ff;
    nxt_bit_cnt  = bit_cnt_ff;
    nxt_shift    = shift_ff;
    nxt_crc      = crc_ff;
    nxt_crc_bnd  = crc_bnd_ff;
    nxt_hold     = hold_ff;
    nxt_hold_v   = hold_v_ff;
    nxt_hold_op  = hold_op_ff;
    nxt_first    = first_ff;
    nxt_ovr_fr   = ovr_fr_ff;
    push         = 1'b0;
    push_data    = {hold_op_ff, 1'b0, 1'b0, hold_ff};
    ev_abort     = 1'b0;
    ev_crce      = 1'b0;
    ev_valid     = 1'b0;
    if (link_bit_en) begin
      if (link_bit) begin
        nxt_ones = (ones_ff == 3'h7) ? ones_ff : ones_ff + 3'h1;
      end else begin
        nxt_ones = 3'h0;
      end
    end
    if (abort_hit) begin
      ev_abort     = 1'b1;
      nxt_in_frame = 1'b0;
      nxt_hold_v   = 1'b0;
      if (in_frame_ff && hold_v_ff) begin
        push      = 1'b1;
        push_data = {hold_op_ff, 1'b1, 1'b0, hold_ff};
      end
    end else if (flag_hit) begin
      if (frame_end) begin
        push      = 1'b1;
        push_data = {hold_op_ff, 1'b1, crc_good & ~ovr_fr_ff, hold_ff};
        ev_crce   = ~crc_good;
        // A dropped last byte spoils the packet as well
        ev_valid  = crc_good & ~ovr_fr_ff & ~fifo_full;
      end
      // Every flag opens a fresh frame; shared flags are allowed
      nxt_in_frame = 1'b1;
      nxt_bit_cnt  = 3'h0;
      nxt_crc      = CRC_INIT;
      nxt_hold_v   = 1'b0;
      nxt_first    = 1'b1;
      nxt_ovr_fr   = 1'b0;
    end else if (data_hit) begin
      nxt_shift   = byte_new;
      nxt_crc     = crc_new;
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      if (byte_done) begin
        // One byte held back so the closing tag can be attached
        push        = hold_v_ff;
        nxt_hold    = byte_new;
        nxt_hold_v  = 1'b1;
        nxt_hold_op = first_ff;
        nxt_first   = 1'b0;
        nxt_crc_bnd = crc_new;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      // Ones right after reset still count toward an abort
      ones_ff     <= 3'h0;
      in_frame_ff <= 1'b0;
      bit_cnt_ff  <= 3'h0;
      shift_ff    <= 8'h00;
      crc_ff      <= CRC_INIT;
      crc_bnd_ff  <= 16'h0000;
      hold_ff     <= 8'h00;
      hold_v_ff   <= 1'b0;
      hold_op_ff  <= 1'b0;
      first_ff    <= 1'b0;
      ovr_fr_ff   <= 1'b0;
    end else begin
      ones_ff     <= nxt_ones;
      in_frame_ff <= nxt_in_frame;
      bit_cnt_ff  <= nxt_bit_cnt;
      shift_ff    <= nxt_shift;
      crc_ff      <= nxt_crc;
      crc_bnd_ff  <= nxt_crc_bnd;
      hold_ff     <= nxt_hold;
      hold_v_ff   <= nxt_hold_v;
      hold_op_ff  <= nxt_hold_op;
      first_ff    <= nxt_first;
      // Overrun at a shared flag must not spoil the next frame
      ovr_fr_ff   <= nxt_ovr_fr | (push & fifo_full & ~flag_hit);
    end
  end

  // ==========================================================
  // Receive FIFO
  wire               rd_fifo  = reg_rd & (reg_addr == ADDR_FIFO_DATA);
  wire               ev_ovr   = push & fifo_full;

  rhs_tag_fifo u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .push      (push),
    .push_data (push_data),
    .pop       (rd_fifo),
    .head_data (head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // ==========================================================
  // Code detector: eight ones, 0, six code bits, 0
  logic [15:0] code_sh_ff,  nxt_code_sh;
  logic [5:0]  cand_ff,     nxt_cand;
  logic [1:0]  match_ff,    nxt_match;
  logic [5:0]  quiet_ff,    nxt_quiet;
  logic        live_ff,     nxt_live;
  logic [5:0]  code_ff,     nxt_code;

  wire [15:0] sh_in      = {code_sh_ff[14:0], link_bit};
  wire        code_match = (sh_in[15:8] == 8'hFF) & ~sh_in[7] & ~sh_in[0];
  // Oldest code bit lands in bit 0
  wire [5:0]  code_seen  = {sh_in[1], sh_in[2], sh_in[3],
                            sh_in[4], sh_in[5], sh_in[6]};

  always_comb begin
    nxt_code_sh = code_sh_ff;
    nxt_cand    = cand_ff;
    nxt_match   = match_ff;
    nxt_quiet   = quiet_ff;
    nxt_live    = live_ff;
    nxt_code    = code_ff;
    if (link_bit_en) begin
      nxt_code_sh = sh_in;
      if (code_match) begin
        nxt_quiet = 6'h00;
        nxt_cand  = code_seen;
        if (code_seen != cand_ff) begin
          nxt_match = 2'h1;
        end else if (match_ff != CODE_CONFIRM) begin
          nxt_match = match_ff + 2'h1;
        end
        if (code_seen == cand_ff && match_ff + 2'h1 >= CODE_CONFIRM) begin
          nxt_live = 1'b1;
          nxt_code = code_seen;
        end
      end else if (quiet_ff == CODE_LOSS) begin
        // Long gap without the pattern means the code is gone
        nxt_live  = 1'b0;
        nxt_match = 2'h0;
      end else begin
        nxt_quiet = quiet_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      code_sh_ff <= 16'h0000;
      cand_ff    <= 6'h00;
      match_ff   <= 2'h0;
      quiet_ff   <= 6'h00;
      live_ff    <= 1'b0;
      code_ff    <= CODE_RESET;
    end else begin
      code_sh_ff <= nxt_code_sh;
      cand_ff    <= nxt_cand;
      match_ff   <= nxt_match;
      quiet_ff   <= nxt_quiet;
      live_ff    <= nxt_live;
      code_ff    <= nxt_code;
    end
  end

  // ==========================================================
  // Sticky flags, cleared by reading their register
  logic [3:0] pkt_flags_ff;
  logic       code_latch_ff;
  wire        rd_info = reg_rd & (reg_addr == ADDR_PKT_INFO);
  wire        rd_code = reg_rd & (reg_addr == ADDR_CODE_STAT);
  wire        code_rise = nxt_live & ~live_ff;
  wire [3:0]  pkt_set = {ev_abort, ev_crce, ev_ovr, ev_valid};

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_flags_ff  <= 4'h0;
      code_latch_ff <= 1'b0;
    end else begin
      // Set beats clear in the same cycle
      pkt_flags_ff  <= (rd_info ? 4'h0 : pkt_flags_ff) | pkt_set;
      code_latch_ff <= (~rd_code & code_latch_ff) | code_rise;
    end
  end

  // ==========================================================
  // Interrupt status and mask, write one to clear
  logic [EV_W-1:0] evt_stat_ff;
  logic [EV_W-1:0] evt_mask_ff;
  wire  [EV_W-1:0] evt_set = {code_rise, ev_valid, ev_ovr, ev_crce, ev_abort};
  wire             wr_stat = reg_wr & (reg_addr == ADDR_EVT_STAT);
  wire             wr_mask = reg_wr & (reg_addr == ADDR_EVT_MASK);
  wire  [EV_W-1:0] stat_clr = wr_stat ? reg_wdata[EV_W-1:0] : '0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      evt_stat_ff <= '0;
      evt_mask_ff <= '0;
    end else begin
      evt_stat_ff <= (evt_stat_ff & ~stat_clr) | evt_set;
      if (wr_mask) begin
        evt_mask_ff <= reg_wdata[EV_W-1:0];
      end
    end
  end

  assign irq = |(evt_stat_ff & evt_mask_ff);

  // ==========================================================
  // Read path, data one cycle after the strobe
  wire [7:0] info_val = {pkt_flags_ff, fifo_empty,
                         ~fifo_empty & head[8],
                         ~fifo_empty & head[9],
                         ~fifo_empty & head[10]};
  wire [7:0] code_val = {code_latch_ff, live_ff, code_ff};
  wire [7:0] fifo_val = fifo_empty ? 8'h00 : head[7:0];
  logic [7:0] rd_mux;
  logic [7:0] rdata_ff;

  always_comb begin
    case (reg_addr)
      ADDR_PKT_INFO:  rd_mux = info_val;
      ADDR_CODE_STAT: rd_mux = code_val;
      ADDR_FIFO_DATA: rd_mux = fifo_val;
      ADDR_EVT_STAT:  rd_mux = {3'h0, evt_stat_ff};
      ADDR_EVT_MASK:  rd_mux = {3'h0, evt_mask_ff};
      default:        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule : rhs_top

// File: testbench/rhs_link_far.sv
// Remote link equipment: sends flags, framed packets and codes.
// Assumes the bench queues bits through the tasks below.
`timescale 1ns/1ps
module rhs_link_far
  import rhs_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  output logic      link_bit = 1'h0,
  output logic      link_bit_en = 1'h0
);
  logic q[$];
  int   gap = 0;
  int   wait_cnt = 0;
  int   ones = 0;

  // ==========================================================
  // Bit builders
  task automatic raw(input logic b);
    q.push_back(b);
  endtask : raw
  // Zero inserted after five data ones
  task automatic put(input logic b);
    raw(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      raw(1'h0);
      ones = 0;
    end
  endtask : put
  task automatic flag();
    for (int i = 0; i < 8; i++) raw(i != 0 && i != 7);
    ones = 0;
  endtask : flag
  // A bad frame flips one check bit
  task automatic frame(input logic [7:0] d[$], input logic bad);
    logic [15:0] c;
    c = CRC_INIT;
    flag();
    foreach (d[i]) for (int k = 0; k < 8; k++) begin
      put(d[i][k]);
      c = (c[0] ^ d[i][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    c = ~c ^ {15'h0, bad};
    for (int k = 0; k < 16; k++) put(c[k]);
    flag();
  endtask : frame
  task automatic code(input logic [5:0] v, input int n);
    repeat (n) begin
      repeat (8) raw(1'h1);
      raw(1'h0);
      for (int k = 0; k < 6; k++) raw(v[k]);
      raw(1'h0);
    end
  endtask : code

  // ==========================================================
  // Line driver: idle line toggles each cycle, starting from the inverse of the last bit
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link_bit_en <= 1'h0;
      wait_cnt    <= 0;
    end else if (q.size() > 0 && wait_cnt >= gap) begin
      link_bit    <= q.pop_front();
      link_bit_en <= 1'h1;
      wait_cnt    <= 0;
    end else begin
      link_bit    <= ~link_bit;
      link_bit_en <= 1'h0;
      wait_cnt    <= wait_cnt + 1;
    end
  end
endmodule : rhs_link_far

// File: testbench/rhs_top_bench.sv
// Self-checking bench for the receive packet and code status block.
// Assumes the link model and the bound checker beside rhs_top.
`timescale 1ns/1ps
module rhs_top_bench
  import rhs_pkg::*;
;
  typedef struct packed {
    logic [7:0] dat;
    logic       bad;
    logic [7:0] info1;
    logic [7:0] info2;
  } rhs_row_s;
  localparam rhs_row_s ROWS [3] = '{'{8'hA5, 1'h0, 8'h11, 8'h06},
    '{8'h3C, 1'h1, 8'h41, 8'h02}, '{8'hFF, 1'h0, 8'h11, 8'h06}};
  logic       sys_clk = 1'h0;
  logic       nrst = 1'h0;
  logic       reg_wr = 1'h0;
  logic       reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       link_bit;
  logic       link_bit_en;
  logic [7:0] reg_rdata;
  logic       irq;
  logic [7:0] d;
  logic [7:0] bq[$];
  int         error_cnt = 0;
  int         comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  rhs_link_far far (.sys_clk(sys_clk), .nrst(nrst), .link_bit(link_bit),
    .link_bit_en(link_bit_en));
  rhs_top DUT (.sys_clk(sys_clk), .nrst(nrst), .link_bit(link_bit),
    .link_bit_en(link_bit_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  // ==========================================================
  // Bus and check tasks
  task automatic chk(input string n, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Strobes stay put until the next call, so calls run back to back
  task automatic cyc(input logic r, w, input logic [7:0] a, wd);
    reg_rd <= r;
    reg_wr <= w;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask : cyc
  task automatic rd(input logic [7:0] a, e, input string n);
    cyc(1'h1, 1'h0, a, 8'h00);
    chk(n, e, d);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) cyc(1'h0, 1'h0, 8'h00, 8'h00);
  endtask : idle
  task automatic drain();
    for (int i = 0; i < 3000 && far.q.size() > 0; i++) idle(1);
    idle(4);
  endtask : drain
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'h1;
    rd(ADDR_PKT_INFO, 8'h08, "reset info");
    rd(ADDR_CODE_STAT, 8'h3F, "reset code");
    rd(ADDR_FIFO_DATA, 8'h00, "empty data");
    rd(8'h20, 8'h00, "unmapped");
    cyc(1'h0, 1'h1, ADDR_PKT_INFO, 8'hFF);
    rd(ADDR_PKT_INFO, 8'h08, "read only info");
    foreach (ROWS[i]) begin
      bq = '{ROWS[i].dat};
      far.frame(bq, ROWS[i].bad);
      drain();
      rd(ADDR_PKT_INFO, ROWS[i].info1, "frame info");
      rd(ADDR_FIFO_DATA, ROWS[i].dat, "frame data");
      cyc(1'h1, 1'h0, ADDR_FIFO_DATA, 8'h00);
      rd(ADDR_PKT_INFO, ROWS[i].info2, "closing info");
      cyc(1'h1, 1'h0, ADDR_FIFO_DATA, 8'h00);
      rd(ADDR_PKT_INFO, 8'h08, "drained info");
      chk("masked irq", 8'h00, {7'h0, irq});
    end
    // Abort inside a frame, then two reads to see it cleared
    far.flag();
    for (int k = 0; k < 8; k++) far.put(~k[0]);
    repeat (7) far.raw(1'h1);
    drain();
    cyc(1'h1, 1'h0, ADDR_PKT_INFO, 8'h00);
    chk("abort", 8'h80, d & 8'h80);
    cyc(1'h1, 1'h0, ADDR_PKT_INFO, 8'h00);
    chk("abort cleared", 8'h00, d & 8'hF0);
    repeat (3) cyc(1'h1, 1'h0, ADDR_FIFO_DATA, 8'h00);
    rd(ADDR_PKT_INFO, 8'h08, "after abort");
    // Slow sender overfills the fifo while the host stalls
    cyc(1'h0, 1'h1, ADDR_EVT_STAT, 8'h1F);
    cyc(1'h0, 1'h1, ADDR_EVT_MASK, 8'h04);
    rd(ADDR_EVT_MASK, 8'h04, "mask");
    bq.delete();
    for (int i = 0; i < 70; i++) bq.push_back(i[7:0]);
    far.gap = 1;
    far.frame(bq, 1'h0);
    drain();
    rd(ADDR_PKT_INFO, 8'h21, "overrun info");
    chk("irq raised", 8'h01, {7'h0, irq});
    rd(ADDR_EVT_STAT, 8'h04, "event status");
    cyc(1'h0, 1'h1, ADDR_EVT_MASK, 8'h00);
    idle(1);
    chk("irq masked", 8'h00, {7'h0, irq});
    cyc(1'h0, 1'h1, ADDR_EVT_MASK, 8'h04);
    cyc(1'h0, 1'h1, ADDR_EVT_STAT, 8'h04);
    idle(2);
    chk("irq cleared", 8'h00, {7'h0, irq});
    for (int i = 0; i < FIFO_DEPTH; i++) rd(ADDR_FIFO_DATA, i[7:0], "fifo");
    rd(ADDR_PKT_INFO, 8'h08, "flushed info");
    // Code: poll every cycle so the live rise is caught
    far.gap = 0;
    far.code(6'h2B, 3);
    for (int i = 0; i < 200 && d[CS_LIVE] !== 1'h1; i++)
      cyc(1'h1, 1'h0, ADDR_CODE_STAT, 8'h00);
    chk("code seen", 8'hEB, d);
    drain();
    rd(ADDR_CODE_STAT, 8'h6B, "code held");
    repeat (40) far.raw(1'h0);
    drain();
    rd(ADDR_CODE_STAT, 8'h2B, "code lost");
    rd(ADDR_CODE_STAT, 8'h2B, "code kept");
    // Reset mid-run: code back to all ones, flags and mask gone
    idle(2);
    nrst <= 1'h0;
    idle(2);
    nrst <= 1'h1;
    rd(ADDR_CODE_STAT, 8'h3F, "code after reset");
    rd(ADDR_PKT_INFO, 8'h08, "info after reset");
    rd(ADDR_EVT_MASK, 8'h00, "mask after reset");
    give_verdict();
  end

  // Whole run needs about 2000 cycles
  initial begin
    repeat (10000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule : rhs_top_bench

// File: testbench/rhs_top_sva.sv
// Checker watching the register port and link inputs of rhs_top.
// Assumes the single sys_clk domain and the package register map.
`timescale 1ns/1ps
module rhs_top_chk
  import rhs_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       link_bit,
  input wire logic       link_bit_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Helper logic
  logic       rd_info;
  logic       rd_code;
  logic [2:0] ones_ff;
  logic [1:0] age_ff;
  logic       pend_ff;
  logic       fresh_ff;
  assign rd_info = reg_rd && reg_addr == ADDR_PKT_INFO;
  assign rd_code = reg_rd && reg_addr == ADDR_CODE_STAT;

  // Only the seventh one arms the check, as the flag is set once per run
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ones_ff  <= 3'h0;
      age_ff   <= 2'h0;
      pend_ff  <= 1'h0;
      fresh_ff <= 1'h1;
    end else begin
      if (link_bit_en) begin
        ones_ff  <= !link_bit ? 3'h0 : ones_ff + {2'h0, ones_ff != 3'h7};
        fresh_ff <= 1'h0;
      end
      if (link_bit_en && link_bit && ones_ff == 3'h6) begin
        pend_ff <= 1'h1;
        age_ff  <= 2'h0;
      end else begin
        if (rd_info) pend_ff <= 1'h0;
        if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
      end
    end
  end

  // ==========================================================
  // Assertions
  sequence s_quiet_rd(logic [7:0] a);
    !link_bit_en && reg_rd && reg_addr == a;
  endsequence
  sequence s_quiet_pair(logic [7:0] a);
    !link_bit_en [*2] ##1 s_quiet_rd(a) ##1 s_quiet_rd(a);
  endsequence

  a_sticky_read_clear: assert property (
    s_quiet_pair(ADDR_PKT_INFO) |=> reg_rdata[7:4] == 4'h0)
    else $error("packet flags survived a read");
  a_latch_read_clear: assert property (
    s_quiet_pair(ADDR_CODE_STAT) |=> !reg_rdata[CS_LATCH])
    else $error("code latch survived a read");
  a_code_held_quiet: assert property (
    s_quiet_pair(ADDR_CODE_STAT) |=> $stable(reg_rdata[6:0]))
    else $error("code changed without link bits");
  a_latch_on_rise: assert property (
    rd_code ##1 (rd_code && !reg_rdata[CS_LIVE]) ##1 reg_rdata[CS_LIVE]
    |-> reg_rdata[CS_LATCH])
    else $error("live code rise not latched");
  a_empty_no_tags: assert property (
    rd_info ##1 reg_rdata[PI_EMPTY] |-> reg_rdata[2:0] == 3'h0)
    else $error("byte tags shown on empty fifo");
  a_ok_needs_close: assert property (
    rd_info ##1 reg_rdata[PI_OK] |-> reg_rdata[PI_CLOSE])
    else $error("packet ok without closing byte");
  a_abort_after_ones: assert property (
    rd_info && pend_ff && age_ff >= 2'h2 |=> reg_rdata[PI_ABORT])
    else $error("seven ones did not flag abort");
  a_code_reset_ones: assert property (
    rd_code && fresh_ff |=> reg_rdata == {2'h0, CODE_RESET})
    else $error("code bits not all ones after reset");
  a_irq_mask_off: assert property (
    reg_wr && reg_addr == ADDR_EVT_MASK && reg_wdata == 8'h00 |=> !irq)
    else $error("interrupt still high with mask cleared");
endmodule : rhs_top_chk

bind rhs_top rhs_top_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .link_bit(link_bit), .link_bit_en(link_bit_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq));
